// file: src/mcore_pkg.sv
package mcore_pkg;

    // data path and register port widths
    localparam int DATA_W = 16;
    localparam int RADDR_W = 4;

    // register offsets on the plain register port
    localparam logic [3:0] OFF_INSTR    = 4'h0;
    localparam logic [3:0] OFF_IMM      = 4'h1;
    localparam logic [3:0] OFF_BD_ADDR  = 4'h2;
    localparam logic [3:0] OFF_BD_DATA  = 4'h3;
    localparam logic [3:0] OFF_STATUS   = 4'h4;
    localparam logic [3:0] OFF_WAIT     = 4'h5;
    localparam logic [3:0] OFF_ALU_BASE = 4'h8;

    // instruction word encodings
    localparam logic [10:0] WAIT_OPC   = 11'h1a8;
    localparam logic [15:0] WRSPI_WORD = 16'h3541;
    localparam logic [12:0] XOR_OPC    = 13'h05da;

    // field layout
    localparam int WAIT_MASK_W   = 5;
    localparam int WAIT_MASK_LSB = 0;
    localparam int TGT_W         = 3;
    localparam int TGT_LSB       = 0;

    // status register bit positions
    localparam int ST_ZERO_BIT    = 0;
    localparam int ST_ONES_BIT    = 1;
    localparam int ST_BD_BUSY_BIT = 2;
    localparam int ST_BD_FAIL_BIT = 3;
    localparam int ST_ILLEGAL_BIT = 4;

    // reset values and constants
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [4:0]  RST_ROWS   = 5'h00;
    localparam logic [4:0]  ALL_ROWS   = 5'h1f;
    localparam logic [15:0] WORD_ZERO  = 16'h0000;
    localparam logic [15:0] WORD_ONES  = 16'hffff;

    // backdoor write latency in core clocks, issue to completion
    localparam int BD_CYCLES = 2;

    // one backdoor write request
    typedef struct packed {
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bd_req_t;

    // condition flags produced by the alu
    typedef struct packed {
        logic all_zero;
        logic all_ones;
    } alu_flags_t;

    function automatic logic is_wait(input logic [15:0] w);
        return w[15:WAIT_MASK_W] == WAIT_OPC;
    endfunction : is_wait

    function automatic logic is_wrspi(input logic [15:0] w);
        return w == WRSPI_WORD;
    endfunction : is_wrspi

    function automatic logic is_xor(input logic [15:0] w);
        return w[15:TGT_W] == XOR_OPC;
    endfunction : is_xor

    function automatic logic [4:0] wait_rows(input logic [15:0] w);
        return w[WAIT_MASK_LSB +: WAIT_MASK_W];
    endfunction : wait_rows

endpackage : mcore_pkg

// file: src/xor_mask_alu.sv
`timescale 1ns/1ps
module xor_mask_alu
    import mcore_pkg::*;
(
    input  wire logic [DATA_W-1:0] operand,
    input  wire logic [DATA_W-1:0] immediate,
    output logic      [DATA_W-1:0] result,
    output alu_flags_t             flags
);

    // pure combinational mask, registered by the caller
    always_comb begin
        result         = operand ^ immediate;
        flags.all_zero = (result == WORD_ZERO);
        flags.all_ones = (result == WORD_ONES);
    end

endmodule : xor_mask_alu

// file: src/backdoor_writer.sv
`timescale 1ns/1ps
module backdoor_writer
    import mcore_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    resetn,
    input  wire logic    start,
    input  wire bd_req_t req,
    input  wire logic    regs_touched,
    input  wire bd_req_t req_now,
    output logic         busy,
    output logic         wr_ff,
    output bd_req_t      out_ff,
    output logic         fail_ff
);

    typedef enum logic [1:0] {
        BD_IDLE = 2'b01,
        BD_BUSY = 2'b10
    } bd_state_t;

    bd_state_t state_ff;
    bd_state_t nxt_state;
    bd_req_t   hold_ff;
    bd_req_t   nxt_hold;
    logic      nxt_wr;
    bd_req_t   nxt_out;
    logic      nxt_fail;

    assign busy = (state_ff == BD_BUSY);

    // issue cycle latches the request, second cycle drives it out
    always_comb begin
        nxt_state = state_ff;
        nxt_hold  = hold_ff;
        nxt_wr    = 1'b0;
        nxt_out   = out_ff;
        nxt_fail  = 1'b0;
        unique case (state_ff)
            BD_IDLE: begin
                if (start) begin
                    nxt_state = BD_BUSY;
                    nxt_hold  = req;
                end
            end
            BD_BUSY: begin
                nxt_state = BD_IDLE;
                nxt_wr    = 1'b1;
                nxt_out   = hold_ff;
                // a change under way garbles the data, not the address
                if (regs_touched) begin
                    nxt_out.data = hold_ff.data ^ req_now.data;
                    nxt_fail     = 1'b1;
                end
            end
            default: nxt_state = BD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= BD_IDLE;
            hold_ff  <= '0;
            wr_ff    <= 1'b0;
            out_ff   <= '0;
            fail_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hold_ff  <= nxt_hold;
            wr_ff    <= nxt_wr;
            out_ff   <= nxt_out;
            fail_ff  <= nxt_fail;
        end
    end

endmodule : backdoor_writer

// file: src/microcore_wait_spi_xor_ops.sv
// What this block does
// - wait mask gives one enable per row, bit 0 row 1 to bit 4
// - backdoor write instruction issues a register write, no operands
// - backdoor write completes two core clocks after issue
// - touching address or data right after issue corrupts the write
// - xor mixes selected alu register with immediate, writes it back
// - xor target is an alu register coded in the lowest bits
// - xor sets all-zero flag on zero, all-ones flag on 0xffff
`timescale 1ns/1ps
module microcore_wait_spi_xor_ops
    import mcore_pkg::*;
#(
    parameter int NUM_ALU_REGS = 8
)(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [RADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    output logic                     bd_wr,
    output logic      [DATA_W-1:0]   bd_addr,
    output logic      [DATA_W-1:0]   bd_data,
    output logic      [4:0]          wait_rows_en,
    output logic                     all_rows_selected,
    output logic                     wait_strobe,
    output logic                     mask_all_zero_flag,
    output logic                     mask_all_ones_flag
);

    // architectural state
    // array sized by the parameter
    logic [DATA_W-1:0] alu_register_subset [NUM_ALU_REGS];
    logic [DATA_W-1:0] alu_immediate_reg_ff;
    logic [DATA_W-1:0] bd_addr_reg_ff;
    logic [DATA_W-1:0] bd_data_reg_ff;
    logic [DATA_W-1:0] last_instr_ff;
    logic [4:0]        wait_row_select_field_ff;
    logic              all_rows_ff;
    logic              wait_strobe_ff;
    alu_flags_t        flags_ff;
    logic              illegal_ff;
    logic              bd_fail_sticky_ff;
    logic [DATA_W-1:0] rdata_ff;

    // next values
    logic [DATA_W-1:0] nxt_alu_reg;
    logic              nxt_alu_we;
    logic [TGT_W-1:0]  nxt_alu_idx;
    logic [DATA_W-1:0] nxt_imm;
    logic [DATA_W-1:0] nxt_bd_addr_reg;
    logic [DATA_W-1:0] nxt_bd_data_reg;
    logic [DATA_W-1:0] nxt_last_instr;
    logic [4:0]        nxt_wait_rows;
    logic              nxt_all_rows;
    logic              nxt_wait_strobe;
    alu_flags_t        nxt_flags;
    logic              nxt_illegal;
    logic              nxt_bd_fail_sticky;
    logic [DATA_W-1:0] nxt_rdata;

    // decode of the instruction written this cycle
    logic              issue;
    logic              dec_wait;
    logic              dec_wrspi;
    logic              dec_xor;
    logic [TGT_W-1:0]  alu_target_operand;
    logic              target_ok;

    // alu and backdoor wires
    logic [DATA_W-1:0] xor_result;
    alu_flags_t        xor_flags;
    logic              bd_busy;
    logic              bd_start;
    logic              bd_touched;
    logic              bd_wr_q;
    bd_req_t           bd_out_q;
    logic              bd_fail_q;
    bd_req_t           bd_req_reg;
    bd_req_t           bd_req_live;

    // a write to the instruction register is an instruction issue
    // decode shares the bus cycle
    always_comb begin
        issue              = reg_wr && (reg_addr == OFF_INSTR);
        dec_wait           = issue && is_wait(reg_wdata);
        dec_wrspi          = issue && is_wrspi(reg_wdata);
        dec_xor            = issue && is_xor(reg_wdata);
        alu_target_operand = reg_wdata[TGT_LSB +: TGT_W];
        target_ok          = (32'(alu_target_operand) < NUM_ALU_REGS);
    end

    // alu feeds the write port below
    xor_mask_alu u_alu (
        .operand   (alu_register_subset[alu_target_operand]),
        .immediate (alu_immediate_reg_ff),
        .result    (xor_result),
        .flags     (xor_flags)
    );

    // the writer samples the registers as they stand at issue
    always_comb begin
        bd_req_reg.addr  = bd_addr_reg_ff;
        bd_req_reg.data  = bd_data_reg_ff;
        bd_req_live.addr = reg_wdata;
        bd_req_live.data = reg_wdata;
        bd_start         = dec_wrspi && !bd_busy;
        bd_touched       = reg_wr && ((reg_addr == OFF_BD_ADDR) ||
                                      (reg_addr == OFF_BD_DATA));
    end

    // outputs of the writer are flops, except busy, decoded from the state flop
    backdoor_writer u_bd (
        .clk          (clk),
        .resetn       (resetn),
        .start        (bd_start),
        .req          (bd_req_reg),
        .regs_touched (bd_touched),
        .req_now      (bd_req_live),
        .busy         (bd_busy),
        .wr_ff        (bd_wr_q),
        .out_ff       (bd_out_q),
        .fail_ff      (bd_fail_q)
    );

    // alu register file write port, bus load or xor write-back
    // bus load and xor never coincide
    always_comb begin
        nxt_alu_we  = 1'b0;
        nxt_alu_idx = '0;
        nxt_alu_reg = '0;
        if (reg_wr && (reg_addr >= OFF_ALU_BASE)) begin
            nxt_alu_we  = 1'b1;
            nxt_alu_idx = reg_addr[TGT_W-1:0];
            nxt_alu_reg = reg_wdata;
        end else if (dec_xor && target_ok) begin
            nxt_alu_we  = 1'b1;
            nxt_alu_idx = alu_target_operand;
            nxt_alu_reg = xor_result;
        end
    end

    // reset loop clears every register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_ALU_REGS; i++) begin
                alu_register_subset[i] <= RST_WORD;
            end
        end else if (nxt_alu_we) begin
            alu_register_subset[nxt_alu_idx] <= nxt_alu_reg;
        end
    end

    // plain data registers loaded by software
    // a corrupting write still lands
    always_comb begin
        nxt_imm         = alu_immediate_reg_ff;
        nxt_bd_addr_reg = bd_addr_reg_ff;
        nxt_bd_data_reg = bd_data_reg_ff;
        nxt_last_instr  = last_instr_ff;
        if (reg_wr) begin
            unique case (reg_addr)
                OFF_IMM:     nxt_imm         = reg_wdata;
                OFF_BD_ADDR: nxt_bd_addr_reg = reg_wdata;
                OFF_BD_DATA: nxt_bd_data_reg = reg_wdata;
                OFF_INSTR:   nxt_last_instr  = reg_wdata;
                default:     nxt_imm         = alu_immediate_reg_ff;
            endcase
        end
    end

    // software words, no side effects
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alu_immediate_reg_ff <= RST_WORD;
            bd_addr_reg_ff       <= RST_WORD;
            bd_data_reg_ff       <= RST_WORD;
            last_instr_ff        <= RST_WORD;
        end else begin
            alu_immediate_reg_ff <= nxt_imm;
            bd_addr_reg_ff       <= nxt_bd_addr_reg;
            bd_data_reg_ff       <= nxt_bd_data_reg;
            last_instr_ff        <= nxt_last_instr;
        end
    end

    // wait row enables, one bit per table row
    // strobe repeats for an equal mask
    always_comb begin
        nxt_wait_rows   = wait_row_select_field_ff;
        nxt_all_rows    = all_rows_ff;
        nxt_wait_strobe = dec_wait;
        if (dec_wait) begin
            nxt_wait_rows = wait_rows(reg_wdata);
            nxt_all_rows  = (wait_rows(reg_wdata) == ALL_ROWS);
        end
    end

    // enables hold until the next wait
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_row_select_field_ff <= RST_ROWS;
            all_rows_ff              <= 1'b0;
            wait_strobe_ff           <= 1'b0;
        end else begin
            wait_row_select_field_ff <= nxt_wait_rows;
            all_rows_ff              <= nxt_all_rows;
            wait_strobe_ff           <= nxt_wait_strobe;
        end
    end

    // condition flags follow each xor; sticky errors, set beats clear
    always_comb begin
        logic clr_fail;
        logic clr_illegal;
        clr_fail    = reg_wr && (reg_addr == OFF_STATUS) &&
                      reg_wdata[ST_BD_FAIL_BIT];
        clr_illegal = reg_wr && (reg_addr == OFF_STATUS) &&
                      reg_wdata[ST_ILLEGAL_BIT];
        nxt_flags = flags_ff;
        if (dec_xor && target_ok) begin
            nxt_flags = xor_flags;
        end
        nxt_bd_fail_sticky = bd_fail_sticky_ff && !clr_fail;
        if (bd_fail_q) begin
            nxt_bd_fail_sticky = 1'b1;
        end
        nxt_illegal = illegal_ff && !clr_illegal;
        // unknown words, bad targets and a wrspi while busy are dropped
        // refused words are not queued
        if (issue && !(dec_wait || dec_wrspi || dec_xor)) begin
            nxt_illegal = 1'b1;
        end
        if ((dec_xor && !target_ok) || (dec_wrspi && bd_busy)) begin
            nxt_illegal = 1'b1;
        end
    end

    // sticky bits wait for a one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_ff          <= '0;
            bd_fail_sticky_ff <= 1'b0;
            illegal_ff        <= 1'b0;
        end else begin
            flags_ff          <= nxt_flags;
            bd_fail_sticky_ff <= nxt_bd_fail_sticky;
            illegal_ff        <= nxt_illegal;
        end
    end

    // read data is valid the cycle after the strobe, zero otherwise
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            if (reg_addr >= OFF_ALU_BASE) begin
                nxt_rdata = alu_register_subset[reg_addr[TGT_W-1:0]];
            end else begin
                unique case (reg_addr)
                    OFF_INSTR:   nxt_rdata = last_instr_ff;
                    OFF_IMM:     nxt_rdata = alu_immediate_reg_ff;
                    OFF_BD_ADDR: nxt_rdata = bd_addr_reg_ff;
                    OFF_BD_DATA: nxt_rdata = bd_data_reg_ff;
                    OFF_STATUS: begin
                        nxt_rdata[ST_ZERO_BIT]    = flags_ff.all_zero;
                        nxt_rdata[ST_ONES_BIT]    = flags_ff.all_ones;
                        nxt_rdata[ST_BD_BUSY_BIT] = bd_busy;
                        nxt_rdata[ST_BD_FAIL_BIT] = bd_fail_sticky_ff;
                        nxt_rdata[ST_ILLEGAL_BIT] = illegal_ff;
                    end
                    OFF_WAIT: nxt_rdata = {11'h000, wait_row_select_field_ff};
                    default:  nxt_rdata = '0;
                endcase
            end
        end
    end

    // zero between answers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= RST_WORD;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // every output is a flop, here or in the writer
    // no logic between flop and pin
    assign reg_rdata          = rdata_ff;
    assign bd_wr              = bd_wr_q;
    assign bd_addr            = bd_out_q.addr;
    assign bd_data            = bd_out_q.data;
    assign wait_rows_en       = wait_row_select_field_ff;
    assign all_rows_selected  = all_rows_ff;
    assign wait_strobe        = wait_strobe_ff;
    assign mask_all_zero_flag = flags_ff.all_zero;
    assign mask_all_ones_flag = flags_ff.all_ones;

endmodule : microcore_wait_spi_xor_ops

// file: testbench/microcore_wait_spi_xor_ops_sva.sv
`timescale 1ns/1ps
module microcore_wait_spi_xor_ops_sva
    import mcore_pkg::*;
#(
    parameter int NUM_ALU_REGS = 8
)(
    input wire logic               clk,
    input wire logic               resetn,
    input wire logic [RADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0]  reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [DATA_W-1:0]  reg_rdata,
    input wire logic               bd_wr,
    input wire logic [DATA_W-1:0]  bd_addr,
    input wire logic [DATA_W-1:0]  bd_data,
    input wire logic [4:0]         wait_rows_en,
    input wire logic               all_rows_selected,
    input wire logic               wait_strobe,
    input wire logic               mask_all_zero_flag,
    input wire logic               mask_all_ones_flag
);
    logic [15:0] wd_ff, adr_ff, dat_ff, cap_a_ff, cap_d_ff;
    logic [15:0] imm_ff, xres_ff, rd_ff;
    logic [15:0] alu_ff [NUM_ALU_REGS];
    logic        spi_ff, wait_ff;
    // decoded issues; a wrspi in the busy cycle is refused, so not counted
    wire instr   = reg_wr && reg_addr == OFF_INSTR;
    wire spi_go  = instr && reg_wdata == WRSPI_WORD && !spi_ff;
    wire wait_go = instr && reg_wdata[15:5] == WAIT_OPC;
    wire xor_go  = instr && reg_wdata[15:3] == XOR_OPC;
    wire touch   = reg_wr && (reg_addr == OFF_BD_ADDR ||
                              reg_addr == OFF_BD_DATA);
    // shadow copy of the software-visible state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {wd_ff, adr_ff, dat_ff, cap_a_ff, cap_d_ff} <= '0;
            {imm_ff, xres_ff, rd_ff, spi_ff, wait_ff} <= '0;
            for (int i = 0; i < NUM_ALU_REGS; i++) alu_ff[i] <= '0;
        end else begin
            wd_ff <= reg_wdata;
            spi_ff <= spi_go;
            wait_ff <= wait_go;
            rd_ff <= alu_ff[reg_addr[2:0]];
            if (reg_wr && reg_addr == OFF_BD_ADDR) adr_ff <= reg_wdata;
            if (reg_wr && reg_addr == OFF_BD_DATA) dat_ff <= reg_wdata;
            if (reg_wr && reg_addr == OFF_IMM) imm_ff <= reg_wdata;
            if (reg_wr && reg_addr[3]) alu_ff[reg_addr[2:0]] <= reg_wdata;
            if (spi_go) begin
                cap_a_ff <= adr_ff;
                cap_d_ff <= dat_ff;
            end
            if (xor_go) begin
                alu_ff[reg_wdata[2:0]] <= alu_ff[reg_wdata[2:0]] ^ imm_ff;
                xres_ff <= alu_ff[reg_wdata[2:0]] ^ imm_ff;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_spi_quiet;
        spi_go ##1 !touch;
    endsequence
    sequence s_spi_dirty;
        spi_go ##1 touch;
    endsequence
    property p_wait_rows;
        wait_go |=> wait_rows_en == wd_ff[4:0];
    endproperty
    a_wait_rows: assert property (p_wait_rows)
        else $error("row enables differ from mask");
    property p_all_rows;
        wait_go |=> wait_strobe && all_rows_selected == (&wd_ff[4:0]);
    endproperty
    a_all_rows: assert property (p_all_rows)
        else $error("all rows output wrong");
    property p_strobe_cause;
        wait_strobe |-> wait_ff;
    endproperty
    a_strobe_cause: assert property (p_strobe_cause)
        else $error("wait strobe without wait word");
    property p_rows_hold;
        !wait_go |=> $stable(wait_rows_en);
    endproperty
    a_rows_hold: assert property (p_rows_hold)
        else $error("row enables moved");
    property p_spi_lat;
        spi_go |=> !bd_wr ##1 bd_wr ##1 !bd_wr;
    endproperty
    a_spi_lat: assert property (p_spi_lat)
        else $error("backdoor strobe not two cycles after issue");
    property p_bd_cause;
        bd_wr |-> $past(spi_go, 2);
    endproperty
    a_bd_cause: assert property (p_bd_cause)
        else $error("backdoor strobe without issue");
    property p_bd_clean;
        s_spi_quiet |=> bd_addr == cap_a_ff && bd_data == cap_d_ff;
    endproperty
    a_bd_clean: assert property (p_bd_clean)
        else $error("backdoor address or data wrong");
    property p_bd_dirty;
        s_spi_dirty |=> bd_addr == cap_a_ff && bd_data == (cap_d_ff ^ wd_ff);
    endproperty
    a_bd_dirty: assert property (p_bd_dirty)
        else $error("corrupted write value wrong");
    property p_xor_flags;
        xor_go |=> mask_all_zero_flag == (xres_ff == WORD_ZERO) &&
                   mask_all_ones_flag == (xres_ff == WORD_ONES);
    endproperty
    a_xor_flags: assert property (p_xor_flags)
        else $error("xor flags wrong");
    property p_flags_hold;
        !xor_go |=> $stable(mask_all_zero_flag) && $stable(mask_all_ones_flag);
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flags moved without xor");
    property p_read_alu;
        reg_rd && reg_addr[3] |=> reg_rdata == rd_ff;
    endproperty
    a_read_alu: assert property (p_read_alu)
        else $error("alu register read back wrong");
endmodule : microcore_wait_spi_xor_ops_sva

bind microcore_wait_spi_xor_ops microcore_wait_spi_xor_ops_sva
    #(.NUM_ALU_REGS(NUM_ALU_REGS)) u_sva (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bd_wr(bd_wr), .bd_addr(bd_addr),
    .bd_data(bd_data), .wait_rows_en(wait_rows_en),
    .all_rows_selected(all_rows_selected), .wait_strobe(wait_strobe),
    .mask_all_zero_flag(mask_all_zero_flag),
    .mask_all_ones_flag(mask_all_ones_flag));

// file: testbench/spi_regspace_model.sv
`timescale 1ns/1ps
module spi_regspace_model (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        bd_wr,
    input wire logic [15:0] bd_addr,
    input wire logic [15:0] bd_data
);
    logic [15:0] mem_ff [16];
    int          wr_count_ff;
    // takes every strobe as is; it cannot tell dummy data from real
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_count_ff <= 0;
        end else if (bd_wr) begin
            mem_ff[bd_addr[3:0]] <= bd_data;
            wr_count_ff <= wr_count_ff + 1;
        end
    end
endmodule : spi_regspace_model

// file: testbench/tb_microcore_wait_spi_xor_ops.sv
`timescale 1ns/1ps
module tb_microcore_wait_spi_xor_ops
    import mcore_pkg::*;
;
    logic        clk, resetn, reg_wr, reg_rd, bd_wr, wait_strobe;
    logic        all_rows_selected, mask_all_zero_flag, mask_all_ones_flag;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, bd_addr, bd_data;
    logic [4:0]  wait_rows_en;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    microcore_wait_spi_xor_ops #(.NUM_ALU_REGS(8)) dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bd_wr(bd_wr), .bd_addr(bd_addr),
        .bd_data(bd_data), .wait_rows_en(wait_rows_en),
        .all_rows_selected(all_rows_selected), .wait_strobe(wait_strobe),
        .mask_all_zero_flag(mask_all_zero_flag),
        .mask_all_ones_flag(mask_all_ones_flag));
    spi_regspace_model spi_space (.clk(clk), .resetn(resetn), .bd_wr(bd_wr),
        .bd_addr(bd_addr), .bd_data(bd_data));

    // 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far above the roughly 90 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // one bus cycle; outputs seen on return are those of the cycle before
    task automatic cyc(input logic w, input logic r, input logic [3:0] a,
                       input logic [15:0] d);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic idle();
        cyc(1'b0, 1'b0, 4'h0, 16'h0000);
    endtask : idle
    // read data stands in reg_rdata on return
    task automatic rd(input logic [3:0] a);
        cyc(1'b0, 1'b1, a, 16'h0000);
        idle();
    endtask : rd

    task automatic t_misc();
        rd(OFF_STATUS);
        chk(reg_rdata, 16'h0000, "status after reset");
        chk(bd_addr | bd_data, 16'h0000, "backdoor after reset");
        wr(4'h6, 16'hbeef);
        rd(4'h6);
        chk(reg_rdata, 16'h0000, "unmapped read");
        wr(OFF_INSTR, 16'hffff);
        rd(OFF_STATUS);
        chk(reg_rdata & 16'h0010, 16'h0010, "unknown word flag");
        wr(OFF_STATUS, 16'h0018);
    endtask : t_misc

    task automatic t_wait();
        logic [4:0] masks [8] = '{5'h01, 5'h02, 5'h04, 5'h08,
                                  5'h10, 5'h15, 5'h1f, 5'h0e};
        foreach (masks[i]) begin
            wr(OFF_INSTR, {WAIT_OPC, masks[i]});
            idle();
            chk(16'(wait_rows_en), 16'(masks[i]), "rows");
            chk(16'(all_rows_selected), 16'(&masks[i]), "all");
            chk(16'(wait_strobe), 16'h0001, "wait strobe");
        end
        rd(OFF_WAIT);
        chk(reg_rdata, 16'h000e, "wait back");
    endtask : t_wait

    task automatic t_spi_clean();
        int n0;
        n0 = spi_space.wr_count_ff;
        wr(OFF_BD_ADDR, 16'h0005);
        wr(OFF_BD_DATA, 16'hc3a1);
        wr(OFF_INSTR, WRSPI_WORD);
        wr(OFF_INSTR, WRSPI_WORD); // refused, backdoor busy
        chk(16'(bd_wr), 16'h0000, "strobe too early");
        idle();
        chk(16'(bd_wr), 16'h0001, "strobe at two cycles");
        idle();
        chk(16'(spi_space.wr_count_ff - n0), 16'h0001, "count");
        chk(spi_space.mem_ff[5], 16'hc3a1, "written value");
        rd(OFF_STATUS);
        chk(reg_rdata & 16'h0018, 16'h0010, "busy refusal");
        wr(OFF_STATUS, 16'h0018);
        wr(OFF_INSTR, WRSPI_WORD);
        rd(OFF_STATUS);
        chk(reg_rdata & 16'h0004, 16'h0004, "busy");
        rd(OFF_BD_DATA);
        chk(reg_rdata, 16'hc3a1, "data back");
    endtask : t_spi_clean

    task automatic t_spi_dirty();
        wr(OFF_BD_ADDR, 16'h000a);
        wr(OFF_BD_DATA, 16'h1234);
        wr(OFF_INSTR, WRSPI_WORD);
        wr(OFF_BD_DATA, 16'h00ff); // breaks the hold on purpose
        idle();
        chk(bd_addr, 16'h000a, "dirty address");
        chk(bd_data, 16'h12cb, "dirty data");
        rd(OFF_STATUS);
        chk(reg_rdata & 16'h0008, 16'h0008, "fail sticky");
        wr(OFF_STATUS, 16'h0018);
        rd(OFF_STATUS);
        chk(reg_rdata & 16'h0018, 16'h0000, "sticky cleared");
    endtask : t_spi_dirty

    task automatic t_xor();
        logic [2:0]  ops  [3] = '{3'd0, 3'd7, 3'd3};
        logic [15:0] vals [3] = '{16'h1234, 16'h00ff, 16'ha5a5};
        logic [15:0] imms [3] = '{16'h1234, 16'hff00, 16'h0f0f};
        logic [15:0] res;
        foreach (ops[i]) begin
            res = vals[i] ^ imms[i];
            wr(OFF_IMM, imms[i]);
            wr(OFF_ALU_BASE + 4'(ops[i]), vals[i]);
            wr(OFF_INSTR, {XOR_OPC, ops[i]});
            idle();
            chk(16'(mask_all_zero_flag), 16'(~|res), "zero");
            chk(16'(mask_all_ones_flag), 16'(&res), "ones");
            rd(OFF_ALU_BASE + 4'(ops[i]));
            chk(reg_rdata, res, "xor result");
        end
        rd(OFF_IMM);
        chk(reg_rdata, 16'h0f0f, "imm back");
    endtask : t_xor

    // main sequence
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        resetn    = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_misc();
        t_wait();
        t_spi_clean();
        t_spi_dirty();
        t_xor();
        idle();
        stop_test();
    end
endmodule : tb_microcore_wait_spi_xor_ops
